//--- common/xcd_pkg.sv
// constants and types for the execute-io command decoder
package xcd_pkg;
  // command codes decoded inside the block
  localparam logic [15:0] C_SET_IRQ_MASK = 16'h2000, C_CLEAR_IRQ_REQUEST = 16'h2001,
    C_IRQ_GLOBAL_ON = 16'h2002, C_IRQ_GLOBAL_OFF = 16'h2003,
    C_CLEAR_PENDING_IRQ = 16'h2004, C_WRITE_FAULT_MASK = 16'h2006,
    C_WRITE_OUTPUT_DISCRETES = 16'h2008, C_CLEAR_POWER_UP_LINE = 16'h200a,
    C_PANEL_OUTPUT_WORD = 16'h4000, C_NULL_OUT = 16'h4001,
    C_WRITE_TIMER_A_RELOAD = 16'h4002, C_PROTECT_UNIT_ON = 16'h4003,
    C_BOOT_ROM_ON = 16'h4004, C_BOOT_ROM_OFF = 16'h4005,
    C_DMA_PERMIT_ON = 16'h4006, C_DMA_PERMIT_OFF = 16'h4007,
    C_TRIGGER_RESTART = 16'h400b, C_WRITE_TIMER_B_RELOAD = 16'h400f,
    C_SET_FAULT_BITS = 16'h0401, C_WRITE_TRIGGER_RELOAD = 16'h040e,
    C_READ_OUTPUT_DISCRETES = 16'h800a, C_PEEK_FAULTS = 16'h8401,
    C_PANEL_ORDER = 16'h8402, C_READ_FAIL_ADDRESS = 16'h8407,
    C_READ_FAIL_PAGE = 16'h8408, C_READ_INTERNAL_CONFIG = 16'h840c,
    C_READ_TRIGGER_RELOAD = 16'h840e, C_READ_EXTERNAL_CONFIG = 16'h8410,
    C_READ_IRQ_MASK = 16'ha000, C_READ_PENDING_IRQS = 16'ha004,
    C_READ_FAULT_MASK = 16'ha006, C_READ_BANK_SELECT = 16'ha00c,
    C_READ_MEM_FAULT_STATE = 16'ha00d, C_READ_CLEAR_FAULTS = 16'ha00f,
    C_PANEL_INPUT_WORD = 16'hc000, C_NULL_IN = 16'hc001,
    C_READ_TIMER_A_RELOAD = 16'hc002, C_READ_TIMER_B_RELOAD = 16'hc00f;
  // code ranges, matched on the upper byte or nibble
  localparam logic [7:0] R_LOAD_PROTECT_RAM = 8'h50, R_FETCH_PROTECT_RAM = 8'hd0,
    R_WRITE_FETCH_PAGE = 8'h51, R_WRITE_OPERAND_PAGE = 8'h52,
    R_READ_FETCH_PAGE = 8'hd1, R_READ_OPERAND_PAGE = 8'hd2, R_LOCAL_OUT = 8'h40,
    R_LOCAL_IN = 8'hc0;
  localparam logic [3:0] N_EXT_PROTECT_OUT = 4'h4, N_EXT_PROTECT_IN = 4'hc;
  // configuration word presence bits
  localparam int CFG_BOOT_ROM = 0, CFG_DMA = 1, CFG_PROTECT = 2, CFG_MMU = 3;
  localparam logic [15:0] CFG_RESET = 16'h000f;
  // fault register bits raised by the decoder itself
  localparam int FLT_PRIV = 0, FLT_ILL_IO = 1;
  // register offsets on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0, REG_CONFIG = 4'h1, REG_STATUS = 4'h2,
    REG_FAULT = 4'h3, REG_PENDING = 4'h4, REG_MASK = 4'h5;
  // control register layout and reset values
  localparam int CTRL_PS_LSB = 0, CTRL_PS_W = 4, CTRL_MODE_B = 4;
  localparam logic [4:0] CTRL_RESET = 5'h01;
  localparam logic [3:0] PS_UNPRIV = 4'h0;
  localparam logic POWER_UP_RESET = 1'b1;
  localparam logic POWER_UP_CLEARED = 1'b0;
  typedef enum logic [5:0] {
    OP_ILLEGAL, OP_NULL, OP_SET_MASK, OP_CLR_REQ, OP_IRQ_ON, OP_IRQ_OFF, OP_CLR_PEND,
    OP_RD_PEND, OP_RD_MASK, OP_RD_CLR_FAULT, OP_SET_FAULT, OP_PEEK_FAULT, OP_WR_TA,
    OP_WR_TB, OP_RD_TA, OP_RD_TB, OP_TRIG_GO, OP_WR_TRIG, OP_RD_TRIG, OP_BOOT_ON,
    OP_BOOT_OFF, OP_DMA_ON, OP_DMA_OFF, OP_NPU_CLR, OP_WR_DISC, OP_RD_DISC, OP_RD_ICFG,
    OP_RD_MFS, OP_RD_MFA, OP_RD_MFP, OP_WR_FMASK, OP_RD_FMASK, OP_RD_BANK, OP_EXT
  } xcd_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RELEASE = 2'b11
  } xcd_state_t;
endpackage

//--- src/xcd_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module xcd_sync3 (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule

//--- src/xcd_classify.sv
// command code classifier: operation, external cycle and legality
`timescale 1ns/100ps
module xcd_classify (
  input wire logic [15:0] code,
  input wire logic mode_b,
  input wire logic [15:0] cfg,
  output xcd_pkg::xcd_op_t op,
  output logic ext
);
  logic need_boot;
  logic need_dma;
  logic need_prot;
  logic need_mmu;
  logic need_b;
  always_comb begin
    op = xcd_pkg::OP_ILLEGAL;
    ext = 1'b0;
    need_boot = 1'b0;
    need_dma = 1'b0;
    need_prot = 1'b0;
    need_mmu = 1'b0;
    need_b = 1'b0;
    case (code)
      xcd_pkg::C_SET_IRQ_MASK: op = xcd_pkg::OP_SET_MASK;
      xcd_pkg::C_CLEAR_PENDING_IRQ: op = xcd_pkg::OP_CLR_PEND;
      xcd_pkg::C_READ_PENDING_IRQS: op = xcd_pkg::OP_RD_PEND;
      xcd_pkg::C_READ_IRQ_MASK: op = xcd_pkg::OP_RD_MASK;
      xcd_pkg::C_CLEAR_IRQ_REQUEST: op = xcd_pkg::OP_CLR_REQ;
      xcd_pkg::C_IRQ_GLOBAL_ON: op = xcd_pkg::OP_IRQ_ON;
      xcd_pkg::C_IRQ_GLOBAL_OFF: op = xcd_pkg::OP_IRQ_OFF;
      xcd_pkg::C_READ_CLEAR_FAULTS: op = xcd_pkg::OP_RD_CLR_FAULT;
      xcd_pkg::C_SET_FAULT_BITS: op = xcd_pkg::OP_SET_FAULT;
      xcd_pkg::C_PEEK_FAULTS: op = xcd_pkg::OP_PEEK_FAULT;
      xcd_pkg::C_WRITE_TIMER_A_RELOAD: begin op = xcd_pkg::OP_WR_TA; need_b = 1'b1; end
      xcd_pkg::C_WRITE_TIMER_B_RELOAD: begin op = xcd_pkg::OP_WR_TB; need_b = 1'b1; end
      xcd_pkg::C_READ_TIMER_A_RELOAD: begin op = xcd_pkg::OP_RD_TA; need_b = 1'b1; end
      xcd_pkg::C_READ_TIMER_B_RELOAD: begin op = xcd_pkg::OP_RD_TB; need_b = 1'b1; end
      xcd_pkg::C_TRIGGER_RESTART: op = xcd_pkg::OP_TRIG_GO;
      xcd_pkg::C_WRITE_TRIGGER_RELOAD: op = xcd_pkg::OP_WR_TRIG;
      xcd_pkg::C_READ_TRIGGER_RELOAD: op = xcd_pkg::OP_RD_TRIG;
      xcd_pkg::C_BOOT_ROM_ON: begin op = xcd_pkg::OP_BOOT_ON; need_boot = 1'b1; end
      xcd_pkg::C_BOOT_ROM_OFF: begin op = xcd_pkg::OP_BOOT_OFF; need_boot = 1'b1; end
      xcd_pkg::C_DMA_PERMIT_ON: begin op = xcd_pkg::OP_DMA_ON; need_dma = 1'b1; end
      xcd_pkg::C_DMA_PERMIT_OFF: begin op = xcd_pkg::OP_DMA_OFF; need_dma = 1'b1; end
      xcd_pkg::C_CLEAR_POWER_UP_LINE: op = xcd_pkg::OP_NPU_CLR;
      xcd_pkg::C_WRITE_OUTPUT_DISCRETES: begin op = xcd_pkg::OP_WR_DISC; ext = 1'b1; end
      xcd_pkg::C_READ_OUTPUT_DISCRETES: begin op = xcd_pkg::OP_RD_DISC; ext = 1'b1; end
      xcd_pkg::C_READ_INTERNAL_CONFIG: op = xcd_pkg::OP_RD_ICFG;
      xcd_pkg::C_READ_EXTERNAL_CONFIG: begin op = xcd_pkg::OP_EXT; ext = 1'b1; end
      xcd_pkg::C_READ_MEM_FAULT_STATE: op = xcd_pkg::OP_RD_MFS;
      xcd_pkg::C_READ_FAIL_ADDRESS: op = xcd_pkg::OP_RD_MFA;
      xcd_pkg::C_READ_FAIL_PAGE: op = xcd_pkg::OP_RD_MFP;
      xcd_pkg::C_NULL_OUT, xcd_pkg::C_NULL_IN: op = xcd_pkg::OP_NULL;
      xcd_pkg::C_WRITE_FAULT_MASK: begin op = xcd_pkg::OP_WR_FMASK; need_b = 1'b1; end
      xcd_pkg::C_READ_FAULT_MASK: begin op = xcd_pkg::OP_RD_FMASK; need_b = 1'b1; end
      xcd_pkg::C_READ_BANK_SELECT: begin op = xcd_pkg::OP_RD_BANK; need_b = 1'b1; end
      xcd_pkg::C_PROTECT_UNIT_ON: begin op = xcd_pkg::OP_EXT; ext = 1'b1; need_prot = 1'b1; end
      xcd_pkg::C_PANEL_OUTPUT_WORD, xcd_pkg::C_PANEL_ORDER,
      xcd_pkg::C_PANEL_INPUT_WORD: begin op = xcd_pkg::OP_EXT; ext = 1'b1; end
      default: begin
        if (code[15:8] == xcd_pkg::R_LOAD_PROTECT_RAM
            || code[15:8] == xcd_pkg::R_FETCH_PROTECT_RAM) begin
          op = xcd_pkg::OP_EXT;
          ext = 1'b1;
          need_prot = 1'b1;
        end else if (code[15:8] == xcd_pkg::R_WRITE_FETCH_PAGE
            || code[15:8] == xcd_pkg::R_WRITE_OPERAND_PAGE
            || code[15:8] == xcd_pkg::R_READ_FETCH_PAGE
            || code[15:8] == xcd_pkg::R_READ_OPERAND_PAGE) begin
          op = xcd_pkg::OP_EXT;
          ext = 1'b1;
          need_mmu = 1'b1;
        end else if ((code[15:12] == xcd_pkg::N_EXT_PROTECT_OUT
            && code[15:8] != xcd_pkg::R_LOCAL_OUT)
            || (code[15:12] == xcd_pkg::N_EXT_PROTECT_IN
            && code[15:8] != xcd_pkg::R_LOCAL_IN)) begin
          op = xcd_pkg::OP_EXT;
          ext = 1'b1;
          need_prot = 1'b1;
          need_b = 1'b1;
        end
      end
    endcase
    // absent option or wrong mode turns the command into a trap
    if ((need_boot && !cfg[xcd_pkg::CFG_BOOT_ROM]) || (need_dma && !cfg[xcd_pkg::CFG_DMA])
        || (need_prot && !cfg[xcd_pkg::CFG_PROTECT]) || (need_mmu && !cfg[xcd_pkg::CFG_MMU])
        || (need_b && !mode_b)) begin
      op = xcd_pkg::OP_ILLEGAL;
      ext = 1'b0;
    end
  end
endmodule

//--- src/xcd_decoder.sv
// execute-io command decoder: internal registers, traps and external cycles
//
// What this block does
// - privileged commands trap when processor state is zero
// - mask load, pending clear, pending read internal
// - request clear, global enable, disable internal
// - fault read-and-clear empties the fault register
// - fault set ORs bits; peek leaves them
// - timer reload registers accessible only in B mode
// - trigger restart, reload write and readback
// - boot ROM on/off, illegal without ROM
// - DMA permit on/off, gated by configuration
// - clear power-up line drives it low (cleared state) internally
// - discrete write/read also run external cycle
// - internal configuration read stays internal
// - external configuration read is external cycle
// - memory fault state, address, page internal
// - protection unit commands go out externally
// - extended protection ranges external, B mode only
// - page register ranges go out externally
// - operator panel codes go out externally
// - commands for absent options trap as illegal
// - two null codes accepted, no effect
// - fault mask and bank reads B mode only
`timescale 1ns/100ps
module xcd_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_done,
  output logic cmd_illegal,
  output logic [15:0] cmd_rdata,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] irq_raise,
  input wire logic [15:0] fault_raise,
  input wire logic [15:0] mem_fault_state,
  input wire logic [15:0] fail_address,
  input wire logic [15:0] fail_page,
  input wire logic [15:0] bank_select,
  output logic [15:0] irq_mask,
  output logic [15:0] irq_pending,
  output logic irq_enable,
  output logic irq_req_clear,
  output logic dma_enable,
  output logic boot_rom_enable,
  output logic power_up_line,
  output logic trig_restart,
  output logic [15:0] trig_reload,
  output logic [15:0] timer_a_reload,
  output logic [15:0] timer_b_reload,
  output logic [15:0] out_discretes,
  output logic ext_req,
  output logic ext_write,
  output logic [15:0] ext_addr,
  output logic [15:0] ext_wdata,
  input wire logic [15:0] ext_rdata,
  input wire logic ext_ready
);
  logic [4:0] ctrl;
  logic [15:0] cfg;
  logic [15:0] fault;
  logic [15:0] fault_mask;
  logic [15:0] next_fault;
  logic [15:0] next_pending;
  logic ready_s;
  logic accept;
  logic priv_bad;
  logic legal;
  logic trap;
  logic ext;
  logic ext_keep_disc;
  xcd_pkg::xcd_op_t op;
  xcd_pkg::xcd_state_t state;

  xcd_classify u_classify (
    .code(cmd_code),
    .mode_b(ctrl[xcd_pkg::CTRL_MODE_B]),
    .cfg(cfg),
    .op(op),
    .ext(ext)
  );

  // ready comes from another device, so it is synchronised
  xcd_sync3 u_ready_sync (
    .clk(clk),
    .rst(rst),
    .din(ext_ready),
    .q(ready_s)
  );

  // commands arriving while an external cycle runs are dropped
  assign accept = cmd_valid && (state == xcd_pkg::ST_IDLE);
  assign priv_bad = ctrl[xcd_pkg::CTRL_PS_LSB +: xcd_pkg::CTRL_PS_W] == xcd_pkg::PS_UNPRIV;
  assign legal = accept && !priv_bad && (op != xcd_pkg::OP_ILLEGAL);
  assign trap = accept && !legal;

  // register port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= xcd_pkg::CTRL_RESET;
      cfg <= xcd_pkg::CFG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == xcd_pkg::REG_CTRL) begin
        ctrl <= reg_wdata[4:0];
      end
      if (reg_addr == xcd_pkg::REG_CONFIG) begin
        cfg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        xcd_pkg::REG_CTRL: reg_rdata <= {11'h000, ctrl};
        xcd_pkg::REG_CONFIG: reg_rdata <= cfg;
        xcd_pkg::REG_STATUS: reg_rdata <= {11'h000, state == xcd_pkg::ST_IDLE, power_up_line,
                                           boot_rom_enable, dma_enable, irq_enable};
        xcd_pkg::REG_FAULT: reg_rdata <= fault;
        xcd_pkg::REG_PENDING: reg_rdata <= irq_pending;
        xcd_pkg::REG_MASK: reg_rdata <= irq_mask;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // interrupt control; a raise in the clearing cycle survives
  always_comb begin
    next_pending = irq_pending;
    if (legal && op == xcd_pkg::OP_CLR_PEND) begin
      next_pending = irq_pending & ~cmd_wdata;
    end
    next_pending = next_pending | irq_raise;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask <= 16'h0000;
      irq_pending <= 16'h0000;
      irq_enable <= 1'b0;
      irq_req_clear <= 1'b0;
    end else begin
      irq_pending <= next_pending;
      irq_req_clear <= legal && op == xcd_pkg::OP_CLR_REQ;
      if (legal && op == xcd_pkg::OP_SET_MASK) begin
        irq_mask <= cmd_wdata;
      end
      if (legal && op == xcd_pkg::OP_IRQ_ON) begin
        irq_enable <= 1'b1;
      end else if (legal && op == xcd_pkg::OP_IRQ_OFF) begin
        irq_enable <= 1'b0;
      end
    end
  end

  // fault register; set beats the read-and-clear
  always_comb begin
    next_fault = fault;
    if (legal && op == xcd_pkg::OP_RD_CLR_FAULT) begin
      next_fault = 16'h0000;
    end
    if (legal && op == xcd_pkg::OP_SET_FAULT) begin
      next_fault = next_fault | cmd_wdata;
    end
    next_fault = next_fault | fault_raise;
    if (trap) begin
      next_fault[xcd_pkg::FLT_PRIV] = next_fault[xcd_pkg::FLT_PRIV] | priv_bad;
      next_fault[xcd_pkg::FLT_ILL_IO] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault <= 16'h0000;
      fault_mask <= 16'h0000;
    end else begin
      fault <= next_fault;
      if (legal && op == xcd_pkg::OP_WR_FMASK) begin
        fault_mask <= cmd_wdata;
      end
    end
  end

  // timer and trigger reload registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_a_reload <= 16'h0000;
      timer_b_reload <= 16'h0000;
      trig_reload <= 16'h0000;
      trig_restart <= 1'b0;
    end else begin
      trig_restart <= legal && op == xcd_pkg::OP_TRIG_GO;
      if (legal && op == xcd_pkg::OP_WR_TA) begin
        timer_a_reload <= cmd_wdata;
      end
      if (legal && op == xcd_pkg::OP_WR_TB) begin
        timer_b_reload <= cmd_wdata;
      end
      if (legal && op == xcd_pkg::OP_WR_TRIG) begin
        trig_reload <= cmd_wdata;
      end
    end
  end

  // discretes and enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_enable <= 1'b0;
      boot_rom_enable <= 1'b1;
      power_up_line <= xcd_pkg::POWER_UP_RESET;
      out_discretes <= 16'h0000;
    end else if (legal) begin
      case (op)
        xcd_pkg::OP_BOOT_ON: boot_rom_enable <= 1'b1;
        xcd_pkg::OP_BOOT_OFF: boot_rom_enable <= 1'b0;
        xcd_pkg::OP_DMA_ON: dma_enable <= 1'b1;
        xcd_pkg::OP_DMA_OFF: dma_enable <= 1'b0;
        xcd_pkg::OP_NPU_CLR: power_up_line <= xcd_pkg::POWER_UP_CLEARED;
        xcd_pkg::OP_WR_DISC: out_discretes <= cmd_wdata;
        default: power_up_line <= power_up_line;
      endcase
    end
  end

  // external cycle sequencer; waits as long as the far end needs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= xcd_pkg::ST_IDLE;
      ext_req <= 1'b0;
      ext_write <= 1'b0;
      ext_addr <= 16'h0000;
      ext_wdata <= 16'h0000;
      ext_keep_disc <= 1'b0;
    end else begin
      case (state)
        xcd_pkg::ST_IDLE: begin
          if (legal && ext) begin
            state <= xcd_pkg::ST_WAIT;
            ext_req <= 1'b1;
            ext_write <= !cmd_code[15];
            ext_addr <= cmd_code;
            ext_wdata <= cmd_wdata;
            ext_keep_disc <= op == xcd_pkg::OP_RD_DISC;
          end
        end
        xcd_pkg::ST_WAIT: begin
          if (ready_s) begin
            state <= xcd_pkg::ST_RELEASE;
            ext_req <= 1'b0;
          end
        end
        xcd_pkg::ST_RELEASE: begin
          // ready must fall before the next cycle can start
          if (!ready_s) begin
            state <= xcd_pkg::ST_IDLE;
          end
        end
        default: state <= xcd_pkg::ST_IDLE;
      endcase
    end
  end

  // answer to the command issuer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_done <= 1'b0;
      cmd_illegal <= 1'b0;
      cmd_rdata <= 16'h0000;
    end else begin
      cmd_done <= 1'b0;
      cmd_illegal <= 1'b0;
      if (trap) begin
        cmd_done <= 1'b1;
        cmd_illegal <= 1'b1;
        cmd_rdata <= 16'h0000;
      end else if (legal && !ext) begin
        cmd_done <= 1'b1;
        case (op)
          xcd_pkg::OP_RD_PEND: cmd_rdata <= irq_pending;
          xcd_pkg::OP_RD_MASK: cmd_rdata <= irq_mask;
          xcd_pkg::OP_RD_CLR_FAULT, xcd_pkg::OP_PEEK_FAULT: cmd_rdata <= fault;
          xcd_pkg::OP_RD_TA: cmd_rdata <= timer_a_reload;
          xcd_pkg::OP_RD_TB: cmd_rdata <= timer_b_reload;
          xcd_pkg::OP_RD_TRIG: cmd_rdata <= trig_reload;
          xcd_pkg::OP_RD_ICFG: cmd_rdata <= cfg;
          xcd_pkg::OP_RD_MFS: cmd_rdata <= mem_fault_state;
          xcd_pkg::OP_RD_MFA: cmd_rdata <= fail_address;
          xcd_pkg::OP_RD_MFP: cmd_rdata <= fail_page;
          xcd_pkg::OP_RD_FMASK: cmd_rdata <= fault_mask;
          xcd_pkg::OP_RD_BANK: cmd_rdata <= bank_select;
          default: cmd_rdata <= 16'h0000;
        endcase
      end else if (state == xcd_pkg::ST_WAIT && ready_s) begin
        cmd_done <= 1'b1;
        // data is held by the far end while ready stands
        cmd_rdata <= ext_keep_disc ? out_discretes : (ext_write ? 16'h0000 : ext_rdata);
      end
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  a_priv_trap: assert property (accept && priv_bad |=> cmd_illegal && cmd_done && !ext_req)
    else $error("privileged command not trapped");
  a_mask_load: assert property (legal && op == xcd_pkg::OP_SET_MASK
      |=> irq_mask == $past(cmd_wdata))
    else $error("mask not loaded");
  a_irq_on: assert property (legal && op == xcd_pkg::OP_IRQ_ON |=> irq_enable && !ext_req)
    else $error("global enable missing");
  a_fault_clear: assert property (legal && op == xcd_pkg::OP_RD_CLR_FAULT
      |=> cmd_rdata == $past(fault) && fault == $past(fault_raise))
    else $error("fault read-clear wrong");
  a_fault_peek: assert property (legal && op == xcd_pkg::OP_PEEK_FAULT
      |=> fault == ($past(fault) | $past(fault_raise)))
    else $error("fault peek changed register");
  a_mode_gate: assert property (accept && cmd_code == xcd_pkg::C_WRITE_TIMER_A_RELOAD
      && !ctrl[xcd_pkg::CTRL_MODE_B] |=> cmd_illegal && $stable(timer_a_reload))
    else $error("timer reload accepted outside B mode");
  a_boot_gate: assert property (accept && cmd_code == xcd_pkg::C_BOOT_ROM_OFF
      && !cfg[xcd_pkg::CFG_BOOT_ROM] |=> cmd_illegal && $stable(boot_rom_enable))
    else $error("boot rom command without rom");
  a_dma_on: assert property (legal && op == xcd_pkg::OP_DMA_ON |=> dma_enable)
    else $error("dma permit not set");
  a_disc_ext: assert property (legal && op == xcd_pkg::OP_WR_DISC
      |=> ext_req && ext_addr == $past(cmd_code) && out_discretes == $past(cmd_wdata))
    else $error("discrete write without external cycle");
  a_icfg_local: assert property (legal && op == xcd_pkg::OP_RD_ICFG
      |=> cmd_done && cmd_rdata == $past(cfg) && !ext_req)
    else $error("internal config read wrong");
  a_ext_done: assert property (state == xcd_pkg::ST_WAIT && ready_s
      |=> cmd_done && !ext_req ##1 !cmd_done)
    else $error("external cycle not completed");
endmodule

//--- test/xcd_far_end.sv
// far-end model: console, paging and protection units answering cycles
`timescale 1ns/100ps
module xcd_far_end (
  input wire logic clk,
  input wire logic ext_req,
  input wire logic [15:0] ext_addr,
  input wire logic slow,
  output logic ext_ready,
  output logic [15:0] ext_rdata
);
  int cnt = 0;
  initial ext_ready = 1'b0;
  initial ext_rdata = 16'h0000;
  always @(posedge clk) begin
    if (ext_req && !ext_ready) begin
      cnt <= cnt + 1;
      if (cnt >= (slow ? 9 : 1)) begin
        ext_ready <= 1'b1;
        ext_rdata <= ext_addr ^ 16'h5a5a;
      end
    end else if (!ext_req) begin
      // released bus must not keep showing stale data
      ext_ready <= 1'b0;
      cnt <= 0;
      ext_rdata <= ~ext_rdata;
    end
  end
endmodule

//--- test/testbench.sv
// self-checking bench for the execute-io command decoder
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst = 1, cv = 0, wr = 0, rd = 0, rdy, slow = 0;
  logic [15:0] cc = 0, cw = 0, wd = 0, aux = 16'h1234, z = 0, rdat;
  logic [3:0] ra = 0;
  int n_fail = 0, checks = 0;
  // {illegal, external, code}; reserved codes only probe the trap
  logic [17:0] rows [] = '{18'h02000, 18'h02001, 18'h02002, 18'h02003, 18'h02004,
    18'h0a004, 18'h0a00f, 18'h00401, 18'h08401, 18'h0400b, 18'h0040e, 18'h0840e,
    18'h04004, 18'h04005, 18'h04006, 18'h04007, 18'h0200a, 18'h12008, 18'h1800a,
    18'h0840c, 18'h18410, 18'h0a00d, 18'h08407, 18'h08408, 18'h14003, 18'h15012,
    18'h1d012, 18'h15134, 18'h15234, 18'h1d134, 18'h1d234, 18'h14000, 18'h18402,
    18'h1c000, 18'h04001, 18'h0c001, 18'h24002, 18'h2400f, 18'h2c002, 18'h2c00f,
    18'h22006, 18'h2a006, 18'h2a00c, 18'h24123, 18'h20403, 18'h2040c, 18'h20400,
    18'h22105};
  always #12.5 clk = ~clk;
  xcd_decoder dut (.clk(clk), .rst(rst), .cmd_valid(cv), .cmd_code(cc), .cmd_wdata(cw),
    .cmd_done(), .cmd_illegal(), .cmd_rdata(), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(), .irq_raise(z), .fault_raise(z),
    .mem_fault_state(aux), .fail_address(aux), .fail_page(aux), .bank_select(aux),
    .irq_mask(), .irq_pending(), .irq_enable(), .irq_req_clear(), .dma_enable(),
    .boot_rom_enable(), .power_up_line(), .trig_restart(), .trig_reload(),
    .timer_a_reload(), .timer_b_reload(), .out_discretes(), .ext_req(),
    .ext_write(), .ext_addr(), .ext_wdata(), .ext_rdata(rdat), .ext_ready(rdy));
  xcd_far_end far (.clk(clk), .ext_req(dut.ext_req), .ext_addr(dut.ext_addr),
    .slow(slow), .ext_ready(rdy), .ext_rdata(rdat));
  task automatic chk(input string n, input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", n, exp, got);
      n_fail++;
    end
  endtask
  task automatic run(input logic [15:0] c, w, input logic il, ex);
    logic se = 0;
    @(posedge clk);
    cv <= 1; cc <= c; cw <= w;
    @(posedge clk);
    cv <= 0;
    @(negedge clk);
    for (int k = 0; k < 60 && dut.cmd_done !== 1'b1; k++) begin
      se |= (dut.ext_req === 1'b1);
      @(negedge clk);
    end
    chk("illegal", {15'h0, dut.cmd_illegal}, {15'h0, il});
    chk("external", {15'h0, se}, {15'h0, ex});
    chk("done", {15'h0, dut.cmd_done}, 16'h0001);
    repeat (8) @(posedge clk); // far end drops ready, decoder idles again
  endtask
  task automatic rw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1; ra <= a; wd <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rr(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1; ra <= a;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk("reg read", dut.reg_rdata, e);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk("power up", {dut.boot_rom_enable, dut.power_up_line}, 16'h0003);
    rr(4'h1, 16'h000f);
    rr(4'hf, 16'h0000);
    foreach (rows[i]) begin
      slow <= i[0];
      run(rows[i][15:0], 16'h00a5, rows[i][17], rows[i][16]);
    end
    $display("table test done");
    run(16'h2000, 16'h00f0, 0, 0);
    chk("mask", dut.irq_mask, 16'h00f0);
    run(16'ha00f, 0, 0, 0);
    run(16'h0401, 16'h0300, 0, 0);
    run(16'h8401, 0, 0, 0);
    chk("peek", dut.cmd_rdata, 16'h0300);
    run(16'ha00f, 0, 0, 0);
    chk("read clear", dut.cmd_rdata, 16'h0300);
    run(16'ha00f, 0, 0, 0);
    chk("cleared", dut.cmd_rdata, 16'h0000);
    run(16'h8407, 0, 0, 0);
    chk("fail address", dut.cmd_rdata, aux);
    run(16'h8410, 0, 0, 1);
    chk("ext config", dut.cmd_rdata, 16'h8410 ^ 16'h5a5a);
    chk("npu line", {15'h0, dut.power_up_line}, 16'h0000);
    run(16'h2002, 0, 0, 0);
    chk("irq on", {15'h0, dut.irq_enable}, 16'h0001);
    run(16'h4006, 0, 0, 0);
    chk("dma on", {15'h0, dut.dma_enable}, 16'h0001);
    run(16'h040e, 16'h0bee, 0, 0);
    run(16'h840e, 0, 0, 0);
    chk("trigger reload", dut.cmd_rdata, 16'h0bee);
    run(16'h2008, 16'h0055, 0, 1);
    chk("ext wdata", dut.ext_wdata, 16'h0055);
    chk("ext write", {15'h0, dut.ext_write}, 16'h0001);
    run(16'h800a, 0, 0, 1);
    chk("discretes", dut.cmd_rdata, 16'h0055);
    $display("effects test done");
    rw(4'h1, 16'h0000);
    run(16'h4006, 0, 1, 0);
    run(16'h4004, 0, 1, 0);
    chk("dma kept", {15'h0, dut.dma_enable}, 16'h0001);
    chk("boot kept", {15'h0, dut.boot_rom_enable}, 16'h0000);
    rw(4'h1, 16'h000f);
    rw(4'h0, 16'h0000);
    run(16'h2000, 0, 1, 0);
    rw(4'h0, 16'h0011);
    run(16'h4002, 16'h1234, 0, 0);
    chk("timer a", dut.timer_a_reload, 16'h1234);
    run(16'h4123, 0, 0, 1);
    $display("mode test done");
    z <= 16'h0030;
    @(posedge clk);
    z <= 16'h0000;
    run(16'h2004, 16'h0010, 0, 0);
    run(16'ha004, 0, 0, 0);
    chk("pending", dut.cmd_rdata, 16'h0020);
    rr(4'h3, 16'h0033);
    $display("raise test done");
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk("reset mask", dut.irq_mask, 16'h0000);
    chk("reset npu", {15'h0, dut.power_up_line}, 16'h0001);
    rr(4'h0, 16'h0001);
    $display("reset test done");
    give_verdict();
  end
endmodule
